//--- core/iocd_io_cell.sv
// Summary of operation
// - Output pair plus mux sends two bits
// - Two inverse clocks trigger pair alternately
// - Clock manager mirrors clock, adds 180 copy
// - One clock line may be inverted locally
// - Enable path has its own pair
// - Input pair captures alternate bits
// - First bit on first, second on second
// - Opposite constants mirror clock on pin
// - Input stores cascade across differential pair
// - Cascade only for LVDS, RSDS, MINI_LVDS
// - Global reset forces every store low
`timescale 1ns/100ps
`default_nettype none

// Dual-edge register cell for one pin of a differential pair
module iocd_io_cell
    import iocd_pkg::*;
(
    // System clock and reset
    input  wire logic           mclk,
    input  wire logic           reset_n,
    // Configuration levels
    input  wire iocd_clk_mode_t clk_mode,
    input  wire iocd_std_t      io_standard,
    input  wire logic           cascade_request,
    input  wire logic           clock_mirror,
    // Clock lines from pins
    input  wire logic           clk_line_first,
    input  wire logic           clk_line_second,
    // Fabric side, outgoing
    input  wire logic           out_bit_rise,
    input  wire logic           out_bit_fall,
    input  wire logic           enable_rise,
    input  wire logic           enable_fall,
    // Pad of this cell
    input  wire logic           pad_in,
    output logic                pad_out,
    output logic                pad_oe,
    // Pad of the partner cell
    input  wire logic           partner_pad_in,
    // Fabric side, incoming
    output logic                captured_bit_first,
    output logic                captured_bit_second,
    output logic                capture_first_pulse,
    output logic                capture_second_pulse,
    output logic                aligned_bit_first,
    output logic                aligned_bit_second,
    output logic                aligned_valid,
    output logic                cascade_active
);

    // Edge events from the clock manager
    logic first_rise;   // First clock rose
    logic second_rise;  // Second clock rose
    // Data chosen for the output pair
    logic data_first;   // Bit for the first edge
    logic data_second;  // Bit for the second edge

    // Whole state of the input side
    typedef struct packed {
        logic meta_pad;       // First sync stage, own pad
        logic sync_pad;       // Settled own pad
        logic meta_partner;   // First sync stage, partner pad
        logic sync_partner;   // Settled partner pad
        logic input_store_rise;   // Bit taken on the first clock
        logic input_store_fall;   // Bit taken on the second clock
        logic partner_store_fall; // Partner's bit, taken on every second clock, cascade or not
        logic pulse_first;    // Capture strobe, first bit
        logic pulse_second;   // Capture strobe, second bit
        logic aligned_first;  // First bit held in the second domain
        logic aligned_second; // Second bit held in the second domain
        logic pair_pending;   // A first bit waits for its second
        logic aligned_strobe; // Aligned pair refreshed
        logic cascade;        // Cascade in force
    } iocd_in_state_t;

    iocd_in_state_t state;      // Registered state
    iocd_in_state_t next_state; // Next value

    // Edge events; clock lines cross through two flops inside
    iocd_clock_manager u_clock_manager (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .clk_mode    (clk_mode),
        .line_first  (clk_line_first),
        .line_second (clk_line_second),
        .first_rise  (first_rise),
        .second_rise (second_rise)
    );

    // Data select for the output pair
    always_comb begin
        if (clock_mirror) begin
            data_first  = IOCD_MIRROR_FIRST;
            data_second = IOCD_MIRROR_SECOND;
        end else begin
            data_first  = out_bit_rise;
            data_second = out_bit_fall;
        end
    end

    iocd_ddr_pair u_output_pair (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .event_first  (first_rise),
        .event_second (second_rise),
        .d_first      (data_first),
        .d_second     (data_second),
        .q            (pad_out)
    );

    iocd_ddr_pair u_enable_pair (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .event_first  (first_rise),
        .event_second (second_rise),
        .d_first      (enable_rise),
        .d_second     (enable_fall),
        .q            (pad_oe)
    );

    // Input side next-state logic
    always_comb begin
        next_state = state;
        // Pads pass two flops, the same depth as the clock lines,
        // so data keeps its phase against the edge events
        next_state.meta_pad     = pad_in;
        next_state.sync_pad     = state.meta_pad;
        next_state.meta_partner = partner_pad_in;
        next_state.sync_partner = state.meta_partner;
        next_state.pulse_first  = 1'b0;
        next_state.pulse_second = 1'b0;
        next_state.aligned_strobe = 1'b0;

        next_state.cascade = cascade_request && iocd_cascade_ok(io_standard);

        if (first_rise) begin
            next_state.input_store_rise = state.sync_pad;
            next_state.pulse_first      = 1'b1;
        end
        if (second_rise) begin
            next_state.partner_store_fall = state.sync_partner;
            next_state.input_store_fall = state.cascade ? state.sync_partner
                                                        : state.sync_pad;
            next_state.pulse_second     = 1'b1;
        end

        // Pair the bits under the second clock for the fabric
        if (first_rise) begin
            next_state.pair_pending = 1'b1;
        end else if (second_rise && state.pair_pending) begin
            next_state.pair_pending = 1'b0;
        end
        // Refresh only once both halves of a period are in
        if (second_rise && state.pair_pending && !first_rise) begin
            next_state.aligned_first  = state.input_store_rise;
            next_state.aligned_second = next_state.input_store_fall;
            next_state.aligned_strobe = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Fabric outputs, all straight from flops
    assign captured_bit_first   = state.input_store_rise;
    assign captured_bit_second  = state.input_store_fall;
    assign capture_first_pulse  = state.pulse_first;
    assign capture_second_pulse = state.pulse_second;
    assign aligned_bit_first    = state.aligned_first;
    assign aligned_bit_second   = state.aligned_second;
    assign aligned_valid        = state.aligned_strobe;
    assign cascade_active       = state.cascade;

endmodule

`default_nettype wire

//--- core/iocd_pkg.sv
// Shared constants and types for the dual-edge I/O cell
package iocd_pkg;

    // Clocking schemes for the storage pairs
    typedef enum logic [1:0] {
        IOCD_CLK_MANAGER,   // Mirrored clock plus 180 degree copy
        IOCD_CLK_LOCAL_INV, // One line, inverted inside the cell
        IOCD_CLK_TWO_LINES  // Two separate clock lines
    } iocd_clk_mode_t;

    // Electrical standard selected for the pin pair
    typedef enum logic [2:0] {
        IOCD_STD_SINGLE,    // Any single-ended standard
        IOCD_STD_LVDS,      // Differential, cascade capable
        IOCD_STD_RSDS,      // Differential, cascade capable
        IOCD_STD_MINI_LVDS, // Differential, cascade capable
        IOCD_STD_OTHER_DIFF // Differential, no cascade
    } iocd_std_t;

    // Level every storage element takes under reset
    localparam logic IOCD_STORE_RESET = 1'b0;

    // Constant levels driven on the two edges when mirroring a clock
    localparam logic IOCD_MIRROR_FIRST  = 1'b1;
    localparam logic IOCD_MIRROR_SECOND = 1'b0;

    // Depth of every pin synchroniser
    localparam int IOCD_SYNC_STAGES = 2;

    // Only three standards offer the input cascade
    function automatic logic iocd_cascade_ok(input iocd_std_t std);
        iocd_cascade_ok = (std == IOCD_STD_LVDS) || (std == IOCD_STD_RSDS) ||
                          (std == IOCD_STD_MINI_LVDS);
    endfunction

endpackage

//--- core/iocd_clock_manager.sv
`timescale 1ns/100ps
`default_nettype none

// Turns sampled clock lines into first and second clock edge events
module iocd_clock_manager
    import iocd_pkg::*;
(
    // System clock and reset
    input  wire logic           mclk,
    input  wire logic           reset_n,
    // Clocking scheme
    input  wire iocd_clk_mode_t clk_mode,
    // Raw clock lines from pins
    input  wire logic           line_first,
    input  wire logic           line_second,
    // Edge events, one mclk cycle each
    output logic                first_rise,
    output logic                second_rise
);

    // Whole state of the manager
    typedef struct packed {
        logic meta_first;   // First synchroniser stage, first line
        logic sync_first;   // Second stage, first line
        logic last_first;   // Previous settled level, first line
        logic meta_second;  // First synchroniser stage, second line
        logic sync_second;  // Second stage, second line
        logic last_second;  // Previous settled level, second line
    } iocd_cm_state_t;

    iocd_cm_state_t state;      // Registered state
    iocd_cm_state_t next_state; // Next value

    // Next-state logic; the meta stages feed only the sync stages
    always_comb begin
        next_state             = state;
        next_state.meta_first  = line_first;
        next_state.sync_first  = state.meta_first;
        next_state.last_first  = state.sync_first;
        next_state.meta_second = line_second;
        next_state.sync_second = state.meta_second;
        next_state.last_second = state.sync_second;
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Edge decode per scheme
    always_comb begin
        first_rise  = state.sync_first & ~state.last_first;
        second_rise = 1'b0;
        case (clk_mode)
            IOCD_CLK_MANAGER: begin
                second_rise = ~state.sync_first & state.last_first;
            end
            IOCD_CLK_LOCAL_INV: begin
                second_rise = ~state.sync_first & state.last_first;
            end
            IOCD_CLK_TWO_LINES: begin
                second_rise = state.sync_second & ~state.last_second;
            end
            default: begin
                second_rise = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

//--- core/iocd_ddr_pair.sv
`timescale 1ns/100ps
`default_nettype none

// Two storage elements with a selecting multiplexer
module iocd_ddr_pair
    import iocd_pkg::*;
(
    // System clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Edge events
    input  wire logic event_first,
    input  wire logic event_second,
    // Data for each edge
    input  wire logic d_first,
    input  wire logic d_second,
    // Pair output
    output logic      q
);

    // Whole state of the pair
    typedef struct packed {
        logic store_rise;  // Element clocked by the first clock
        logic store_fall;  // Element clocked by the second clock
        logic sel_second;  // Mux points at the second element
        logic q;           // Registered mux output
    } iocd_pair_state_t;

    iocd_pair_state_t state;      // Registered state
    iocd_pair_state_t next_state; // Next value

    // Alternate loads; when both events come in one cycle the second event wins the mux
    always_comb begin
        next_state = state;
        if (event_first) begin
            next_state.store_rise = d_first;
            next_state.sel_second = 1'b0;
        end
        if (event_second) begin
            next_state.store_fall = d_second;
            next_state.sel_second = 1'b1;
        end
        next_state.q = next_state.sel_second ? next_state.store_fall
                                             : next_state.store_rise;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= {IOCD_STORE_RESET, IOCD_STORE_RESET, 1'b0, IOCD_STORE_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign q = state.q;

endmodule

`default_nettype wire

//--- test/iocd_io_cell_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the dual-edge cell
module iocd_io_cell_checker
    import iocd_pkg::*;
(
    // Clock and reset
    input wire logic      mclk,
    input wire logic      reset_n,
    // Configuration and fabric inputs
    input wire iocd_std_t io_standard,
    input wire logic      cascade_request,
    input wire logic      clock_mirror,
    input wire logic      out_bit_rise,
    input wire logic      out_bit_fall,
    input wire logic      enable_rise,
    input wire logic      enable_fall,
    // Watched outputs
    input wire logic      pad_out,
    input wire logic      pad_oe,
    input wire logic      captured_bit_first,
    input wire logic      captured_bit_second,
    input wire logic      capture_first_pulse,
    input wire logic      capture_second_pulse,
    input wire logic      aligned_bit_second,
    input wire logic      aligned_valid,
    input wire logic      cascade_active
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // Each level holds five cycles, so first edges sit ten apart
    sequence quiet_first;
        (!capture_first_pulse)[*5];
    endsequence
    // A first edge with no second edge beside it
    sequence only_first;
        capture_first_pulse && !capture_second_pulse;
    endsequence
    reset_zero_a: assert property ($rose(reset_n) |->
        !(pad_out || pad_oe || captured_bit_first || cascade_active)) else $error("not low");
    cascade_match_a: assert property ($past(reset_n, 2) |-> cascade_active ==
        ($past(cascade_request) && ($past(io_standard) inside {IOCD_STD_LVDS,
        IOCD_STD_RSDS, IOCD_STD_MINI_LVDS}))) else $error("cascade level wrong");
    pulse_space_a: assert property (capture_first_pulse |=> quiet_first)
        else $error("first pulses too close");
    mirror_rise_a: assert property ($past(clock_mirror) ##0 only_first |-> pad_out)
        else $error("mirror high missing");
    mirror_fall_a: assert property ($past(clock_mirror) && capture_second_pulse |->
        !pad_out) else $error("mirror low missing");
    out_rise_a: assert property (!$past(clock_mirror) ##0 only_first |->
        pad_out == $past(out_bit_rise)) else $error("rise bit wrong");
    out_fall_a: assert property (!$past(clock_mirror) && capture_second_pulse |->
        pad_out == $past(out_bit_fall)) else $error("fall bit wrong");
    oe_edges_a: assert property (capture_first_pulse || capture_second_pulse |->
        pad_oe == (capture_second_pulse ? $past(enable_fall) : $past(enable_rise)))
        else $error("enable wrong");
    pad_hold_a: assert property (!capture_first_pulse && !capture_second_pulse |->
        $stable(pad_out) && $stable(pad_oe)) else $error("pad moved between edges");
    store_hold_a: assert property (!capture_first_pulse |->
        $stable(captured_bit_first)) else $error("first store moved");
    aligned_pair_a: assert property (aligned_valid |-> capture_second_pulse &&
        aligned_bit_second == captured_bit_second) else $error("pair misaligned");
endmodule
`default_nettype wire

//--- test/iocd_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// Source-synchronous sender on the far side of the pads
module iocd_src_model (
    // Pin levels
    output var logic clk_first,
    output var logic clk_second,
    output var logic pad,
    output var logic partner_pad
);
    // Clocks stand still between frames
    initial begin
        clk_first = 1'b0;
        clk_second = 1'b1;
        pad = 1'b0;
    end
    assign partner_pad = ~pad;
    // Four 80 ns periods; data moves mid-level, giving 20 ns setup and hold
    task automatic send(input logic [7:0] bits);
        for (int k = 0; k < 4; k++) begin
            pad = bits[7 - 2 * k];
            #20;
            clk_first = 1'b1;
            clk_second = 1'b0;
            #20;
            pad = bits[6 - 2 * k];
            #20;
            clk_first = 1'b0;
            clk_second = 1'b1;
            #20;
        end
        // Released line shows no stale value
        pad = ~pad;
    endtask
endmodule
`default_nettype wire

//--- test/tb_iocd_io_cell.sv
`timescale 1ns/100ps
`default_nettype none
// Bench for the dual-edge cell
module tb_iocd_io_cell import iocd_pkg::*;;
    // Clock, reset and configuration
    logic           mclk            = 1'b0;
    logic           reset_n         = 1'b0;
    iocd_clk_mode_t clk_mode        = IOCD_CLK_LOCAL_INV;
    iocd_std_t      io_standard     = IOCD_STD_SINGLE;
    logic           cascade_request = 1'b0;
    logic           clock_mirror    = 1'b0;
    logic [3:0]     fab             = 4'h0; // Out rise, out fall, oe rise, oe fall
    // Pins and outputs
    wire logic clk_first, clk_second, pad, partner_pad, pad_out, pad_oe;
    wire logic captured_bit_first, captured_bit_second, capture_first_pulse;
    wire logic capture_second_pulse, aligned_bit_first, aligned_bit_second;
    wire logic aligned_valid, cascade_active, any_out;
    int        fail_count = 0;
    int        compares   = 0;
    assign any_out = |{pad_out, pad_oe, captured_bit_first, captured_bit_second,
        capture_first_pulse, capture_second_pulse, aligned_bit_first, aligned_bit_second,
        aligned_valid, cascade_active};
    // 125 MHz
    always #4 mclk = ~mclk;
    iocd_src_model iocd_src_model_i (.clk_first, .clk_second, .pad, .partner_pad);
    iocd_io_cell iocd_io_cell_i (.mclk, .reset_n, .clk_mode, .io_standard,
        .cascade_request, .clock_mirror, .clk_line_first(clk_first),
        .clk_line_second(clk_second), .out_bit_rise(fab[3]), .out_bit_fall(fab[2]),
        .enable_rise(fab[1]), .enable_fall(fab[0]), .pad_in(pad),
        .partner_pad_in(partner_pad), .pad_out, .pad_oe, .captured_bit_first,
        .captured_bit_second, .capture_first_pulse, .capture_second_pulse,
        .aligned_bit_first, .aligned_bit_second, .aligned_valid, .cascade_active);
    task automatic chk(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset for four cycles; everything low during and just after
    task automatic reset_check;
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("outputs in reset", 1'b0, any_out);
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(negedge mclk);
        chk("outputs after release", 1'b0, any_out);
    endtask
    // One frame; bounded watch judges every edge event
    task automatic frame(input iocd_clk_mode_t m, input logic mir, input logic [7:0] b,
                         input logic [3:0] f, input logic inv);
        int nf = 0;
        int ns = 0;
        int na = 0;
        @(posedge mclk);
        clk_mode <= m;
        clock_mirror <= mir;
        fab <= f;
        repeat (2) @(posedge mclk);
        fork
            iocd_src_model_i.send(b);
            repeat (60) begin
                @(negedge mclk);
                if (capture_first_pulse) begin
                    chk("first bit", b[7 - 2 * nf], captured_bit_first);
                    chk("rise pad", mir | f[3], pad_out);
                    chk("rise oe", f[1], pad_oe);
                    nf++;
                end
                if (capture_second_pulse) begin
                    chk("second bit", b[6 - 2 * ns] ^ inv, captured_bit_second);
                    chk("fall pad", !mir & f[2], pad_out);
                    chk("fall oe", f[0], pad_oe);
                    ns++;
                end
                if (aligned_valid) begin
                    chk("aligned first", b[7 - 2 * na], aligned_bit_first);
                    chk("aligned second", b[6 - 2 * na] ^ inv, aligned_bit_second);
                    na++;
                end
            end
        join
        chk("edge count", 1'b1, nf == 4 && ns == 4 && na == 4);
    endtask
    // One line inverted inside the cell
    task automatic local_inv_frame;
        frame(IOCD_CLK_LOCAL_INV, 1'b0, 8'hb4, 4'h9, 1'b0);
    endtask
    // Two separate lines, back-to-back frames
    task automatic two_line_frames;
        frame(IOCD_CLK_TWO_LINES, 1'b0, 8'h6d, 4'h6, 1'b0);
        frame(IOCD_CLK_TWO_LINES, 1'b0, 8'h93, 4'ha, 1'b0);
    endtask
    // Mirrored clock overrides fabric bits
    task automatic mirror_frame;
        frame(IOCD_CLK_MANAGER, 1'b1, 8'h3c, 4'h6, 1'b0);
    endtask
    // Cascade granted only for three standards, then used and withdrawn
    task automatic cascade_scan;
        for (int s = 0; s < 5; s++) begin
            @(posedge mclk);
            io_standard <= iocd_std_t'(s);
            cascade_request <= 1'b1;
            repeat (3) @(negedge mclk);
            chk("cascade", io_standard inside {IOCD_STD_LVDS, IOCD_STD_RSDS,
                IOCD_STD_MINI_LVDS}, cascade_active);
        end
        // Configuration moves on a rising edge like the mode and fabric inputs
        @(posedge mclk);
        io_standard <= IOCD_STD_LVDS;
        frame(IOCD_CLK_MANAGER, 1'b0, 8'ha5, 4'h5, 1'b1);
        @(posedge mclk);
        cascade_request <= 1'b0;
        frame(IOCD_CLK_LOCAL_INV, 1'b0, 8'h5a, 4'hf, 1'b0);
    endtask
    initial begin
        reset_check();
        local_inv_frame();
        two_line_frames();
        mirror_frame();
        cascade_scan();
        reset_check();
        print_verdict();
    end
endmodule
bind iocd_io_cell iocd_io_cell_checker iocd_io_cell_checker_i (.mclk, .reset_n,
    .io_standard, .cascade_request, .clock_mirror, .out_bit_rise, .out_bit_fall,
    .enable_rise, .enable_fall, .pad_out, .pad_oe, .captured_bit_first,
    .captured_bit_second, .capture_first_pulse, .capture_second_pulse,
    .aligned_bit_second, .aligned_valid, .cascade_active);
`default_nettype wire
